//--- inc/timer2_defs.vh
// constants for the sixteen-bit capture/reload timer
`ifndef TIMER2_DEFS_VH
`define TIMER2_DEFS_VH
`define OSC_PER_MCYCLE 4'hC
`define OSC_PER_STATE 4'h2
`define PHASE_FIRST 4'h0
`define PHASE_LAST 4'hB
`define PHASE_SAMPLE 4'h9
`define PHASE_JUDGE 4'hA
`define PHASE_APPLY 4'h4
`define COUNT_RESET 16'h0000
`define COUNT_ONE 16'h0001
`define COUNT_TOP 16'hFFFF
`define STATE_LAST 1'h1
`endif

//--- rtl/timer2_capture_reload_counter.v
// sixteen-bit timer/counter with capture, auto-reload and baud modes
`timescale 1ns/1ps
`include "timer2_defs.vh"

module timer2_capture_reload_counter (
    input wire clk,
    input wire rst_b,
    input wire runControl,
    input wire timerOrCounterSelect,
    input wire captureReloadSelect,
    input wire externalEdgeEnable,
    input wire transmitClockSelect,
    input wire receiveClockSelect,
    input wire downCountEnableWr,
    input wire downCountEnableIn,
    input wire countInputPin,
    input wire externalTriggerPin,
    input wire countWrHigh,
    input wire countWrLow,
    input wire captureWrHigh,
    input wire captureWrLow,
    input wire [7:0] wrData,
    input wire overflowFlagClr,
    input wire externalEdgeFlagClr,
    output reg [7:0] countHighByte,
    output reg [7:0] countLowByte,
    output reg [7:0] captureHighByte,
    output reg [7:0] captureLowByte,
    output reg overflowFlag,
    output reg externalEdgeFlag,
    output reg downCountEnable,
    output wire [1:0] modeState,
    output wire irqRequest
);

localparam MODE_OFF = 2'h0;
localparam MODE_RELOAD = 2'h1;
localparam MODE_CAPTURE = 2'h2;
localparam MODE_BAUD = 2'h3;

////////////////////////////////////////////////////////////////////////////////
// shared decode and arithmetic

function [1:0] selectMode;
    input run;
    input serialClk;
    input captureSel;
    begin
        if (!run) begin
            selectMode = MODE_OFF;
        end else if (serialClk) begin
            selectMode = MODE_BAUD;
        end else if (captureSel) begin
            selectMode = MODE_CAPTURE;
        end else begin
            selectMode = MODE_RELOAD;
        end
    end
endfunction

function stepEnable;
    input [1:0] modeSel;
    input counting;
    input pinEvent;
    input stateTick;
    input cycleEnd;
    begin
        if (modeSel == MODE_OFF) begin
            stepEnable = 1'b0;
        end else if (counting) begin
            stepEnable = pinEvent;
        end else if (modeSel == MODE_BAUD) begin
            stepEnable = stateTick;
        end else begin
            stepEnable = cycleEnd;
        end
    end
endfunction

function fallingPair;
    input older;
    input newer;
    begin
        fallingPair = older & ~newer;
    end
endfunction

function [15:0] stepValue;
    input [15:0] value;
    input down;
    begin
        if (down) begin
            stepValue = value - `COUNT_ONE;
        end else begin
            stepValue = value + `COUNT_ONE;
        end
    end
endfunction

function atTop;
    input [15:0] value;
    begin
        atTop = (value == `COUNT_TOP);
    end
endfunction

function [15:0] joinBytes;
    input [7:0] high;
    input [7:0] low;
    begin
        joinBytes = {high, low};
    end
endfunction

function [7:0] highOf;
    input [15:0] value;
    begin
        highOf = value[15:8];
    end
endfunction

function [7:0] lowOf;
    input [15:0] value;
    begin
        lowOf = value[7:0];
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// mode decode and oscillator phase

reg [1:0] mode;
reg [3:0] phase_r;
reg stateTick_r;
reg countPinPrev_r;
reg countPinSample_r;
reg trigPinPrev_r;
reg trigPinSample_r;
reg countPending_r;
reg trigPending_r;
wire mcycleEnd;
wire samplePhase;
wire applyPhase;
wire [15:0] count;
wire [15:0] capture;

always @* begin
    mode = selectMode(runControl, transmitClockSelect | receiveClockSelect,
        captureReloadSelect);
end

assign modeState = mode;
assign count = joinBytes(countHighByte, countLowByte);
assign capture = joinBytes(captureHighByte, captureLowByte);
assign mcycleEnd = (phase_r == `PHASE_LAST);
assign samplePhase = (phase_r == `PHASE_SAMPLE);
assign applyPhase = (phase_r == `PHASE_APPLY);
assign irqRequest = overflowFlag | externalEdgeFlag;

always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        phase_r <= `PHASE_FIRST;
        stateTick_r <= 1'b0;
    end else begin
        phase_r <= mcycleEnd ? `PHASE_FIRST : phase_r + 4'h1;
        stateTick_r <= ~stateTick_r;
    end
end

////////////////////////////////////////////////////////////////////////////////
// pin sampling once per machine cycle

always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        countPinPrev_r <= 1'b0;
        countPinSample_r <= 1'b0;
        trigPinPrev_r <= 1'b0;
        trigPinSample_r <= 1'b0;
        countPending_r <= 1'b0;
        trigPending_r <= 1'b0;
    end else begin
        if (samplePhase) begin
            countPinSample_r <= countInputPin;
            countPinPrev_r <= countPinSample_r;
            trigPinSample_r <= externalTriggerPin;
            trigPinPrev_r <= trigPinSample_r;
        end
        // the falling pair is judged just after sampling, applied next cycle
        if (phase_r == `PHASE_JUDGE) begin
            countPending_r <= fallingPair(countPinPrev_r,
                countPinSample_r);
            trigPending_r <= fallingPair(trigPinPrev_r,
                trigPinSample_r);
        end else if (applyPhase) begin
            countPending_r <= 1'b0;
            trigPending_r <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// count, capture and flags

reg countStep;
reg countDown;
reg trigEvent;
reg [15:0] countNxt;
reg [15:0] captureNxt;
reg ovfSet;
reg edgeSet;
reg edgeToggle;

always @* begin
    countDown = (mode == MODE_RELOAD) && downCountEnable
        && !externalTriggerPin;
    trigEvent = applyPhase && trigPending_r && externalEdgeEnable;
    countStep = stepEnable(mode, timerOrCounterSelect,
        applyPhase && countPending_r, stateTick_r, mcycleEnd);
    countNxt = count;
    captureNxt = capture;
    ovfSet = 1'b0;
    edgeSet = 1'b0;
    edgeToggle = 1'b0;
    if (countStep) begin
        if (countDown) begin
            if (count == capture) begin
                countNxt = `COUNT_TOP;
                ovfSet = 1'b1;
                edgeToggle = 1'b1;
            end else begin
                countNxt = stepValue(count, 1'b1);
            end
        end else if (atTop(count)) begin
            if (mode == MODE_CAPTURE) begin
                countNxt = `COUNT_RESET;
                ovfSet = 1'b1;
            end else begin
                countNxt = capture;
                ovfSet = (mode == MODE_RELOAD);
                edgeToggle = (mode == MODE_RELOAD) && downCountEnable;
            end
        end else begin
            countNxt = stepValue(count, 1'b0);
        end
    end
    if (trigEvent && mode != MODE_OFF
        && !(mode == MODE_RELOAD && downCountEnable)) begin
        edgeSet = 1'b1;
        if (mode == MODE_CAPTURE) begin
            captureNxt = count;
        end else if (mode == MODE_RELOAD) begin
            countNxt = capture;
        end
    end
end

always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        countHighByte <= 8'h00;
        countLowByte <= 8'h00;
        captureHighByte <= 8'h00;
        captureLowByte <= 8'h00;
        overflowFlag <= 1'b0;
        externalEdgeFlag <= 1'b0;
        downCountEnable <= 1'b0;
    end else begin
        countHighByte <= countWrHigh ? wrData : highOf(countNxt);
        countLowByte <= countWrLow ? wrData : lowOf(countNxt);
        captureHighByte <= captureWrHigh ? wrData : highOf(captureNxt);
        captureLowByte <= captureWrLow ? wrData : lowOf(captureNxt);
        if (downCountEnableWr) begin
            downCountEnable <= downCountEnableIn;
        end
        if (ovfSet) begin
            overflowFlag <= 1'b1;
        end else if (overflowFlagClr) begin
            overflowFlag <= 1'b0;
        end
        if (edgeToggle) begin
            externalEdgeFlag <= ~externalEdgeFlag;
        end else if (edgeSet) begin
            externalEdgeFlag <= 1'b1;
        end else if (externalEdgeFlagClr) begin
            externalEdgeFlag <= 1'b0;
        end
    end
end

endmodule

//--- verification/timer2_props.sv
// port assertions for the capture/reload timer
`timescale 1ns/1ps
module timer2_props (
    input wire clk, rst_b, timerOrCounterSelect, countWrHigh, countWrLow,
    input wire overflowFlagClr, overflowFlag, externalEdgeFlag,
    input wire downCountEnable, irqRequest,
    input wire [7:0] countHighByte, countLowByte,
    input wire [7:0] captureHighByte, captureLowByte,
    input wire [1:0] modeState
);
default clocking @(posedge clk); endclocking
default disable iff (!rst_b);
wire [15:0] cnt = {countHighByte, countLowByte};
wire [15:0] cap = {captureHighByte, captureLowByte};
wire wr = countWrHigh | countWrLow;
////////////////////////////////////////////////////////////////////////
sequence capStep;
    $changed(cnt) && !$past(wr) && $past(modeState) == 2'h2;
endsequence
a_step_by_one: assert property (capStep |-> cnt == $past(cnt) + 16'h0001)
    else $error("count step not one");
a_timer_spacing: assert property ((capStep and !timerOrCounterSelect)
    |=> ($stable(cnt) || wr || modeState != 2'h2) [*8])
    else $error("timer stepped too soon");
a_off_frozen: assert property (modeState == 2'h0 && !wr |=> $stable(cnt))
    else $error("count moved while off");
a_ovf_sets: assert property ($past(modeState) == 2'h2 && !$past(wr) &&
    $past(cnt) == 16'hFFFF && cnt == 16'h0000 |-> ##[0:1] overflowFlag)
    else $error("overflow flag missing");
a_ovf_sticky: assert property (overflowFlag && !overflowFlagClr |=> overflowFlag)
    else $error("overflow flag dropped");
a_capture_copy: assert property ($rose(externalEdgeFlag) &&
    modeState == 2'h2 |-> cap == $past(cnt))
    else $error("capture value wrong");
a_irq_flags: assert property (irqRequest == (overflowFlag || externalEdgeFlag))
    else $error("request not flag or");
a_reload_ovf: assert property ($past(modeState) == 2'h1 && !downCountEnable
    && $past(cnt) == 16'hFFFF && $changed(cnt) && !$past(wr)
    |-> cnt == $past(cap))
    else $error("reload value wrong");
endmodule
bind timer2_capture_reload_counter timer2_props props (.*);

//--- verification/trig_source.sv
// count and trigger pin source
`timescale 1ns/1ps
module trig_source (
    input wire clk,
    output reg countPin,
    output reg trigPin
);
initial begin
    countPin = 1'b0;
    trigPin = 1'b0;
end
// one falling edge, each level held past a machine cycle
task fall(input sel);
    begin
        @(negedge clk);
        if (sel) trigPin = 1'b1; else countPin = 1'b1;
        repeat (13) @(negedge clk);
        if (sel) trigPin = 1'b0; else countPin = 1'b0;
        repeat (13) @(negedge clk);
    end
endtask
endmodule

//--- verification/timer2_capture_reload_counter_tb.sv
// bench for the capture/reload timer
`timescale 1ns/1ps
module timer2_capture_reload_counter_tb;
reg clk = 0, rst_b = 0;
reg [3:0] m = 0, w = 0, x = 0;
reg [1:0] clr = 0;
reg [7:0] d = 0;
wire cp, tp, of, ef, dce, irq;
wire [7:0] ch, cl, kh, kl;
wire [1:0] ms;
integer fail_count = 0, checks = 0, cyc = 0;
initial begin
    forever #12.5 clk = ~clk;
end
trig_source pm (.clk(clk), .countPin(cp), .trigPin(tp));
timer2_capture_reload_counter uut (.clk(clk), .rst_b(rst_b),
    .runControl(m[3]), .timerOrCounterSelect(m[2]),
    .captureReloadSelect(m[1]), .externalEdgeEnable(m[0]),
    .transmitClockSelect(x[0]), .receiveClockSelect(x[1]),
    .downCountEnableWr(x[2]), .downCountEnableIn(x[3]),
    .countInputPin(cp), .externalTriggerPin(tp),
    .countWrHigh(w[3]), .countWrLow(w[2]), .captureWrHigh(w[1]),
    .captureWrLow(w[0]), .wrData(d), .overflowFlagClr(clr[0]),
    .externalEdgeFlagClr(clr[1]), .countHighByte(ch), .countLowByte(cl),
    .captureHighByte(kh), .captureLowByte(kl), .overflowFlag(of),
    .externalEdgeFlag(ef), .downCountEnable(dce), .modeState(ms),
    .irqRequest(irq));
////////////////////////////////////////////////////////////////////////
task chk(input [15:0] got, input [15:0] exp);
    begin
        checks = checks + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    end
endtask
task wr(input [3:0] s, input [7:0] v);
    begin
        @(negedge clk);
        w = s;
        d = v;
        @(negedge clk);
        w = 0;
    end
endtask
task pulse(input [1:0] s);
    begin
        @(negedge clk);
        clr = s;
        @(negedge clk);
        clr = 0;
    end
endtask
task waitCnt(input [15:0] v);
    integer i;
    begin
        for (i = 0; i < 2000 && {ch, cl} !== v; i = i + 1) @(negedge clk);
    end
endtask
task end_of_test;
    begin
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    end
endtask
always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
        fail_count = fail_count + 1;
        end_of_test;
    end
end
////////////////////////////////////////////////////////////////////////
initial begin
    repeat (20) @(negedge clk);
    rst_b = 1;
    chk({ch, cl, kh, kl} == 32'h0000_0000, 16'h0001);
    chk({12'h000, of, ef, dce, irq}, 16'h0000);
    $display("reset test done");
    wr(4'hC, 8'hFF);
    wr(4'h4, 8'hFE);
    m = 4'hA;
    waitCnt(16'h0000);
    repeat (11) @(negedge clk);
    chk({ch, cl}, 16'h0000);
    @(negedge clk);
    chk({ch, cl}, 16'h0001);
    chk({14'h0000, of, irq}, 16'h0003);
    pulse(2'h1);
    chk({15'h0000, of}, 16'h0000);
    $display("timer test done");
    m = 4'h0;
    wr(4'hC, 8'h00);
    m = 4'hE;
    repeat (3) pm.fall(0);
    repeat (24) @(negedge clk);
    chk({ch, cl}, 16'h0003);
    m = 4'hF;
    pm.fall(1);
    repeat (24) @(negedge clk);
    chk({kh, kl}, 16'h0003);
    chk({14'h0000, ef, irq}, 16'h0003);
    pulse(2'h2);
    $display("counter test done");
    m = 4'h0;
    wr(4'h3, 8'h10);
    wr(4'hC, 8'hFF);
    m = 4'h8;
    waitCnt(16'h1010);
    chk({12'h000, of, ef, dce, irq}, 16'h0009);
    m = 4'h0;
    repeat (40) @(negedge clk);
    chk({ch, cl}, 16'h1010);
    $display("reload test done");
    wr(4'hC, 8'h00);
    x = 4'h2;
    m = 4'h8;
    repeat (20) @(negedge clk);
    chk({14'h0000, ms}, 16'h0003);
    chk({ch, cl}, 16'h000A);
    m = 4'h0;
    x = 4'hC;
    @(negedge clk);
    x = 4'h0;
    chk({15'h0000, dce}, 16'h0001);
    $display("baud test done");
    end_of_test;
end
endmodule
